// file: design/dsc_ctrl.sv
// host-side controller driving an x16 asynchronous dram
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - each address held stable on and after its capturing strobe edge
// - output enable raised before write data is driven in delayed write
// - all 512 rows refreshed within 8 ms, 64 ms for low power
// - row-only refresh keeps column strobe high, external row address
// - hidden refresh keeps column strobe low after read, cycles row strobe
// - column-first refresh lowers column strobe before row strobe
// - battery mode issues column-first refresh every 125 us, row low under 1 us
// - self-refresh holds both strobes low at least 100 us
// - self-refresh exit raises row then column strobe after hold time
// - power-up waits 200 us then eight row strobe cycles
module dsc_ctrl #(
	parameter int PWRUP_CYCLES = dsc_pkg::PWRUP_CYC,
	parameter int REF_CYCLES   = dsc_pkg::REF_INT_CYC,
	parameter int SELF_CYCLES  = dsc_pkg::SELF_CYC,
	parameter int BATT_CYCLES  = dsc_pkg::BATT_CYC,
	parameter bit LOW_POWER    = 1'b0,
	parameter bit USE_CBR      = 1'b1
) (
	// clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	// user request
	input  wire logic                      req_valid,
	output logic                           req_ready,
	input  wire logic [1:0]                req_op,
	input  wire logic [17:0]               req_addr,
	input  wire logic [15:0]               req_wdata,
	input  wire logic [1:0]                req_byte_en,
	input  wire logic                      req_hidden_ref,
	input  wire dsc_pkg::dsc_mode_e        mode,
	output logic                           rsp_valid,
	output logic [15:0]                    rsp_rdata,
	output logic                           init_done,
	output logic                           self_active,
	// dram pins
	output logic                           ras_n,
	output logic                           cas_n,
	output logic                           upper_byte_write_n,
	output logic                           lower_byte_write_n,
	output logic                           oe_n,
	output logic [dsc_pkg::ADDR_W-1:0]     mux_address_pins,
	input  wire logic [15:0]               data_lines_i,
	output logic [15:0]                    data_lines_o,
	output logic [15:0]                    data_lines_oe
);
	import dsc_pkg::*;

	typedef enum logic [4:0] {
		S_PWR, S_INIT_LO, S_INIT_HI, S_IDLE, S_ROW, S_COL, S_CAS, S_WE,
		S_PRE, S_HID_HI, S_HID_LO, S_ROR, S_CBR_CAS, S_CBR_RAS, S_SELF,
		S_SELF_EXIT
	} dsc_state_e;

	dsc_state_e           state_q;
	logic [CNT_W-1:0]     tmr_q;
	logic [CNT_W-1:0]     ref_tmr_q;
	logic [3:0]           init_cnt_q;
	logic                 ref_pend_q;
	logic [ADDR_W-1:0]    ref_row_q;
	logic [1:0]           op_q;
	logic [17:0]          addr_q;
	logic [15:0]          wdata_q;
	logic [1:0]           be_q;
	logic                 hid_q;
	logic [15:0]          din_s1_q;
	logic [15:0]          din_s2_q;
	logic [15:0]          din_s3_q;
	logic                 take;

	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = CNT_W'(n - 1);
	endfunction

	assign take = (state_q == S_IDLE) && req_valid && !ref_pend_q && mode == DSC_MODE_NORMAL;
	assign req_ready = take;

	// three-stage input sync; only stage three feeds the capture
	always_ff @(posedge clk_sys) begin
		din_s1_q <= data_lines_i;
		din_s2_q <= din_s1_q;
		din_s3_q <= din_s2_q;
	end

	always_ff @(posedge clk_sys) begin
		if (take) begin
			op_q    <= req_op;
			addr_q  <= req_addr;
			wdata_q <= req_wdata;
			be_q    <= (req_byte_en == 2'h0) ? 2'h3 : req_byte_en;
			hid_q   <= req_hidden_ref;
		end
	end

	// refresh interval; interval is row budget split over 512 rows
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ref_tmr_q  <= '0;
			ref_pend_q <= 1'b0;
		end else begin
			// at-or-above: leaving battery mode with a long count must not skip the short interval
			if (ref_tmr_q >= cyc(LOW_POWER && mode == DSC_MODE_BATTERY ? BATT_CYCLES : REF_CYCLES)) begin
				ref_tmr_q  <= '0;
				ref_pend_q <= init_done;
			end else begin
				ref_tmr_q <= ref_tmr_q + 1'b1;
				if (state_q == S_ROR || state_q == S_CBR_CAS || state_q == S_HID_HI)
					ref_pend_q <= 1'b0;
			end
		end
	end

	// external row pointer for row-only refresh; device counter serves column-first
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ref_row_q <= '0;
		end else if ((state_q == S_ROR || state_q == S_HID_LO) && tmr_q == '0) begin
			ref_row_q <= ref_row_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q    <= S_PWR;
			tmr_q      <= cyc(PWRUP_CYCLES);
			init_cnt_q <= '0;
			init_done  <= 1'b0;
			rsp_valid  <= 1'b0;
			rsp_rdata  <= '0;
		end else begin
			rsp_valid <= 1'b0;
			if (tmr_q != '0)
				tmr_q <= tmr_q - 1'b1;
			unique case (state_q)
				S_PWR: if (tmr_q == '0) begin
					state_q <= S_INIT_LO;
					tmr_q   <= cyc(RAS_LOW_CYC);
				end
				S_INIT_LO: if (tmr_q == '0) begin
					state_q    <= S_INIT_HI;
					tmr_q      <= cyc(RAS_PRE_CYC);
					init_cnt_q <= init_cnt_q + 1'b1;
				end
				S_INIT_HI: if (tmr_q == '0) begin
					if (init_cnt_q == 4'(INIT_RAS_CYCLES)) begin
						state_q   <= S_IDLE;
						init_done <= 1'b1;
					end else begin
						state_q <= S_INIT_LO;
						tmr_q   <= cyc(RAS_LOW_CYC);
					end
				end
				S_IDLE: begin
					if (mode == DSC_MODE_SELF && LOW_POWER) begin
						state_q <= S_CBR_CAS;
						tmr_q   <= cyc(1);
					end else if (ref_pend_q) begin
						state_q <= (USE_CBR || mode == DSC_MODE_BATTERY) ? S_CBR_CAS : S_ROR;
						tmr_q   <= (USE_CBR || mode == DSC_MODE_BATTERY) ? cyc(1) : cyc(RAS_LOW_CYC);
					end else if (take) begin
						state_q <= S_ROW;
						tmr_q   <= cyc(2);
					end
				end
				S_ROW: if (tmr_q == '0) begin
					state_q <= S_COL;
					tmr_q   <= cyc(1);
				end
				S_COL: if (tmr_q == '0) begin
					state_q <= S_CAS;
					tmr_q   <= cyc(ACCESS_CYC + 3); // sync latency on data_lines_i
				end
				S_CAS: if (tmr_q == '0) begin
					if (op_q != OP_WRITE) begin
						rsp_rdata <= din_s3_q;
						rsp_valid <= 1'b1;
					end
					if (op_q == OP_RMW) begin
						state_q <= S_WE;
						tmr_q   <= cyc(2);
					end else if (hid_q && op_q == OP_READ) begin
						state_q <= S_HID_HI;
						tmr_q   <= cyc(RAS_PRE_CYC);
					end else begin
						state_q <= S_PRE;
						tmr_q   <= cyc(RAS_PRE_CYC);
					end
				end
				S_WE: if (tmr_q == '0) begin
					state_q <= S_PRE;
					tmr_q   <= cyc(RAS_PRE_CYC);
				end
				S_PRE: if (tmr_q == '0)
					state_q <= S_IDLE;
				S_HID_HI: if (tmr_q == '0) begin
					state_q <= S_HID_LO;
					tmr_q   <= cyc(RAS_LOW_CYC);
				end
				S_HID_LO: if (tmr_q == '0) begin
					state_q <= S_PRE;
					tmr_q   <= cyc(RAS_PRE_CYC);
				end
				S_ROR: if (tmr_q == '0) begin
					state_q <= S_PRE;
					tmr_q   <= cyc(RAS_PRE_CYC);
				end
				S_CBR_CAS: if (tmr_q == '0) begin
					state_q <= (mode == DSC_MODE_SELF && LOW_POWER) ? S_SELF : S_CBR_RAS;
					tmr_q   <= (mode == DSC_MODE_SELF && LOW_POWER) ? cyc(SELF_CYCLES) : cyc(CAS_LOW_CYC);
				end
				// battery mode ras low stays 2 cycles = 80 ns, well under 1 us
				S_CBR_RAS: if (tmr_q == '0) begin
					state_q <= S_PRE;
					tmr_q   <= cyc(RAS_PRE_CYC);
				end
				S_SELF: if (tmr_q == '0 && mode != DSC_MODE_SELF) begin
					state_q <= S_SELF_EXIT;
					tmr_q   <= cyc(SELF_EXIT_CYC);
				end
				S_SELF_EXIT: if (tmr_q == '0)
					state_q <= S_IDLE;
				default: state_q <= S_IDLE;
			endcase
		end
	end

	assign self_active = (state_q == S_SELF);

	// pin drive decode
	always_comb begin
		ras_n              = 1'b1;
		cas_n              = 1'b1;
		upper_byte_write_n = 1'b1;
		lower_byte_write_n = 1'b1;
		oe_n               = 1'b1;
		mux_address_pins   = addr_q[17:9];
		data_lines_o       = wdata_q;
		data_lines_oe      = '0;
		unique case (state_q)
			S_INIT_LO: ras_n = 1'b0;
			S_ROW: ras_n = (tmr_q != '0); // new row settles a cycle before the fall
			S_COL: begin
				ras_n            = 1'b0;
				mux_address_pins = addr_q[8:0];
				if (op_q == OP_WRITE) begin
					upper_byte_write_n = !be_q[1];
					lower_byte_write_n = !be_q[0];
					data_lines_oe      = {{8{be_q[1]}}, {8{be_q[0]}}};
				end
			end
			S_CAS: begin
				ras_n            = 1'b0;
				cas_n            = 1'b0;
				mux_address_pins = addr_q[8:0];
				if (op_q == OP_WRITE) begin
					upper_byte_write_n = !be_q[1];
					lower_byte_write_n = !be_q[0];
					data_lines_oe      = {{8{be_q[1]}}, {8{be_q[0]}}};
				end else begin
					oe_n = 1'b0;
				end
			end
			S_WE: begin
				ras_n            = 1'b0;
				cas_n            = 1'b0;
				mux_address_pins = addr_q[8:0];
				// oe held high a cycle before data drive
				data_lines_oe    = (tmr_q == '0) ? {{8{be_q[1]}}, {8{be_q[0]}}} : '0;
				upper_byte_write_n = !(be_q[1] && tmr_q == '0);
				lower_byte_write_n = !(be_q[0] && tmr_q == '0);
			end
			S_HID_HI: begin
				cas_n = 1'b0;
				oe_n  = 1'b0;
			end
			S_HID_LO: begin
				ras_n            = 1'b0;
				cas_n            = 1'b0;
				oe_n             = 1'b0;
				mux_address_pins = ref_row_q;
			end
			S_ROR: begin
				ras_n            = 1'b0;
				mux_address_pins = ref_row_q;
			end
			S_CBR_CAS: cas_n = 1'b0;
			S_CBR_RAS, S_SELF: begin
				ras_n = 1'b0;
				cas_n = 1'b0;
			end
			S_SELF_EXIT: cas_n = (tmr_q < cyc(SELF_EXIT_CYC - CHS_CYC));
			default: ;
		endcase
	end

	// oe never low while host drives data
	oe_vs_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(data_lines_oe != '0) |-> oe_n) else $error("oe low while driving");
	ror_cas_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == S_ROR) |-> cas_n && !ras_n) else $error("row-only refresh wrong strobes");
	sequence cbr_s;
		!cas_n && ras_n ##1 !cas_n && !ras_n;
	endsequence
	cbr_order_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == S_CBR_CAS |-> cbr_s) else $error("cas not first");
	early_wr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(cas_n) && op_q == OP_WRITE && state_q == S_CAS |-> $past(!lower_byte_write_n || !upper_byte_write_n))
		else $error("early write late");
	read_oe_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!oe_n |-> !cas_n) else $error("oe low without cas");
	byte_map_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!lower_byte_write_n |-> data_lines_oe[7:0] == 8'hFF) else $error("lower byte not driven");
	init_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(init_done) |-> init_cnt_q == 4'h8) else $error("init ras count");
	col_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == S_CAS && $past(state_q) == S_COL |-> mux_address_pins == $past(mux_address_pins))
		else $error("column address moved");
	rd_we_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		op_q == OP_READ && state_q == S_CAS |-> lower_byte_write_n && upper_byte_write_n)
		else $error("write enable low on read");
endmodule
`default_nettype wire

// file: design/dsc_pkg.sv
// package of constants for the x16 dram strobe controller
package dsc_pkg;
	localparam int CLK_MHZ          = 25;
	localparam int ADDR_W           = 9;
	localparam int ROWS             = 512;
	localparam int PWRUP_US         = 200;
	localparam int PWRUP_CYC        = PWRUP_US * CLK_MHZ;
	localparam int INIT_RAS_CYCLES  = 8;
	localparam int REFRESH_MS       = 8;
	localparam int REFRESH_LP_MS    = 64;
	localparam int REF_INT_CYC      = (REFRESH_MS * 1000 * CLK_MHZ) / ROWS;
	localparam int REF_INT_LP_CYC   = (REFRESH_LP_MS * 1000 * CLK_MHZ) / ROWS;
	localparam int BATT_US          = 125;
	localparam int BATT_CYC         = BATT_US * CLK_MHZ;
	localparam int SELF_US          = 100;
	localparam int SELF_CYC         = SELF_US * CLK_MHZ + 1;
	localparam int RAS_LOW_CYC      = 3;
	localparam int RAS_PRE_CYC      = 2;
	localparam int CAS_LOW_CYC      = 2;
	localparam int ACCESS_CYC       = 2;
	localparam int CHS_CYC          = 2;
	localparam int SELF_EXIT_CYC    = 5;
	localparam int CNT_W            = 20;
	localparam logic [1:0] OP_READ  = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_RMW   = 2'h2;
	typedef enum logic [1:0] {
		DSC_MODE_NORMAL,
		DSC_MODE_BATTERY,
		DSC_MODE_SELF
	} dsc_mode_e;
endpackage

// file: test/dsc_ctrl_bench.sv
// self-checking bench for the x16 dram strobe controller
`timescale 1ns/1ps
`default_nettype none
module dsc_ctrl_bench;
	import dsc_pkg::*;
	localparam int PW = 20;
	localparam int SC = 10;
	logic        clk_sys, rst_n, req_valid, req_hidden_ref, req_ready, rsp_valid, init_done, self_active;
	logic        ras_n, cas_n, upper_byte_write_n, lower_byte_write_n, oe_n;
	logic [1:0]  req_op, req_byte_en;
	logic [17:0] req_addr;
	logic [15:0] req_wdata, rsp_rdata, data_lines_i, data_lines_o, data_lines_oe, dev_d;
	logic [8:0]  mux_address_pins;
	dsc_mode_e   mode;
	int          bad_count = 0, compares = 0, base;
	logic        r_ras_n, r_cas_n, r_uw_n, r_lw_n, r_oe_n;
	logic [8:0]  r_addr;
	logic [15:0] r_do, r_doe, r_di, r_dev;

	// host lanes where enabled, the memory elsewhere
	assign data_lines_i = (data_lines_o & data_lines_oe) | (dev_d & ~data_lines_oe);
	assign r_di = (r_do & r_doe) | (r_dev & ~r_doe);

	dsc_ctrl #(.PWRUP_CYCLES(PW), .REF_CYCLES(50), .SELF_CYCLES(SC), .BATT_CYCLES(60), .LOW_POWER(1'b1),
		.USE_CBR(1'b1)) uut (
		.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_byte_en(req_byte_en), .req_hidden_ref(req_hidden_ref),
		.mode(mode), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done),
		.self_active(self_active), .ras_n(ras_n), .cas_n(cas_n), .upper_byte_write_n(upper_byte_write_n),
		.lower_byte_write_n(lower_byte_write_n), .oe_n(oe_n), .mux_address_pins(mux_address_pins),
		.data_lines_i(data_lines_i), .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe));

	dsc_dram_model #(.SELF_NS(SC * 40.0)) dram (
		.ras_n(ras_n), .cas_n(cas_n), .upper_byte_write_n(upper_byte_write_n),
		.lower_byte_write_n(lower_byte_write_n), .oe_n(oe_n), .mux_address_pins(mux_address_pins),
		.host_d(data_lines_o), .dev_d(dev_d));

	// second controller doing row-only refresh only
	dsc_ctrl #(.PWRUP_CYCLES(PW), .REF_CYCLES(50), .USE_CBR(1'b0)) uut_ror (
		.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(1'b0), .req_ready(), .req_op(req_op),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_byte_en(req_byte_en), .req_hidden_ref(1'b0),
		.mode(DSC_MODE_NORMAL), .rsp_valid(), .rsp_rdata(), .init_done(), .self_active(), .ras_n(r_ras_n),
		.cas_n(r_cas_n), .upper_byte_write_n(r_uw_n), .lower_byte_write_n(r_lw_n), .oe_n(r_oe_n),
		.mux_address_pins(r_addr), .data_lines_i(r_di), .data_lines_o(r_do), .data_lines_oe(r_doe));

	dsc_dram_model #(.SELF_NS(SC * 40.0)) dram_ror (
		.ras_n(r_ras_n), .cas_n(r_cas_n), .upper_byte_write_n(r_uw_n), .lower_byte_write_n(r_lw_n),
		.oe_n(r_oe_n), .mux_address_pins(r_addr), .host_d(r_do), .dev_d(r_dev));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic end_of_test;
		if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_f(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	function automatic logic sig(input int k);
		case (k)
			0: return req_ready;
			1: return rsp_valid;
			2: return init_done;
			default: return self_active;
		endcase
	endfunction

	// checks just after each edge, where the combinational outputs have settled
	task automatic wait_v(input int k, input logic v, input int lim);
		int i;
		for (i = 0; i < lim && sig(k) !== v; i++) begin
			@(posedge clk_sys);
			#1;
		end
		if (sig(k) !== v) begin
			bad_count++;
			$display("[ERR] %0t wait ran out", $time);
			end_of_test();
		end
	endtask

	task automatic op(input logic [1:0] o, input logic [17:0] a, input logic [15:0] d, input logic [1:0] be,
		input logic h);
		req_op = o;
		req_addr = a;
		req_wdata = d;
		req_byte_en = be;
		req_hidden_ref = h;
		req_valid = 1'b1;
		wait_v(0, 1'b1, 400);
		@(posedge clk_sys);
		#1;
		req_valid = 1'b0;
		// one idle edge before any next request
		@(posedge clk_sys);
		#1;
	endtask

	task automatic rd_chk(input logic [17:0] a, input logic [15:0] exp, input logic h);
		op(OP_READ, a, 16'h0000, 2'h3, h);
		wait_v(1, 1'b1, 20);
		chk_w(rsp_rdata, exp);
	endtask

	task automatic t_init;
		req_valid = 1'b1;
		repeat (PW / 2) @(posedge clk_sys);
		#1;
		chk_f(req_ready, 1'b0);
		chk_f(dram.ras_falls == 0, 1'b1);
		req_valid = 1'b0;
		wait_v(2, 1'b1, PW + 200);
		chk_f(dram.ras_falls >= 8, 1'b1);
	endtask

	task automatic t_words;
		op(OP_WRITE, 18'h2A5F3, 16'hC3A5, 2'h3, 1'b0);
		op(OP_WRITE, 18'h0A5F3, 16'h1234, 2'h3, 1'b0);
		op(OP_WRITE, 18'h2A40C, 16'h0FF0, 2'h3, 1'b0);
		rd_chk(18'h2A5F3, 16'hC3A5, 1'b0);
		rd_chk(18'h0A5F3, 16'h1234, 1'b0);
		rd_chk(18'h2A40C, 16'h0FF0, 1'b0);
		op(OP_WRITE, 18'h3FFFF, 16'hFFFF, 2'h3, 1'b0);
		op(OP_WRITE, 18'h3FFFF, 16'h0011, 2'h1, 1'b0);
		rd_chk(18'h3FFFF, 16'hFF11, 1'b0);
		op(OP_WRITE, 18'h3FFFF, 16'h2200, 2'h2, 1'b0);
		rd_chk(18'h3FFFF, 16'h2211, 1'b0);
	endtask

	task automatic t_rmw;
		op(OP_RMW, 18'h2A5F3, 16'h5A5A, 2'h3, 1'b0);
		rd_chk(18'h2A5F3, 16'h5A5A, 1'b0);
		op(OP_RMW, 18'h0A5F3, 16'h7700, 2'h2, 1'b0);
		rd_chk(18'h0A5F3, 16'h7734, 1'b0);
		chk_f(dram.faults == 0, 1'b1);
	endtask

	task automatic t_refresh;
		base = dram.refs;
		rd_chk(18'h2A40C, 16'h0FF0, 1'b1);
		repeat (3) @(posedge clk_sys);
		#1;
		chk_w(dev_d, 16'h0FF0);
		op(OP_READ, 18'h2A40C, 16'h0000, 2'h3, 1'b0);
		chk_f(dram.refs > base, 1'b1);
		base = dram.refs;
		repeat (260) @(posedge clk_sys);
		#1;
		chk_f(dram.refs - base >= 4, 1'b1);
		chk_f(dram_ror.refs == 0 && dram_ror.ras_falls >= 12, 1'b1);
	endtask

	task automatic t_battery;
		mode = DSC_MODE_BATTERY;
		req_valid = 1'b1;
		repeat (5) @(posedge clk_sys);
		#1;
		chk_f(req_ready, 1'b0);
		dram.ras_max = 0.0;
		base = dram.refs;
		repeat (190) @(posedge clk_sys);
		#1;
		chk_f(dram.refs - base >= 3, 1'b1);
		chk_f(dram.ras_max < 1000.0, 1'b1);
		req_valid = 1'b0;
		mode = DSC_MODE_NORMAL;
	endtask

	task automatic t_self;
		mode = DSC_MODE_SELF;
		wait_v(3, 1'b1, 200);
		repeat (SC * 3) @(posedge clk_sys);
		#1;
		chk_f(ras_n | cas_n, 1'b0);
		mode = DSC_MODE_NORMAL;
		wait_v(3, 1'b0, 200);
		rd_chk(18'h0A5F3, 16'h7734, 1'b0);
		chk_f(dram.self_seen >= 1, 1'b1);
		chk_f(dram.faults == 0, 1'b1);
	endtask

	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req_op = OP_READ;
		req_addr = 18'h00000;
		req_wdata = 16'h0000;
		req_byte_en = 2'h3;
		req_hidden_ref = 1'b0;
		mode = DSC_MODE_NORMAL;
		repeat (12) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		t_init();
		t_words();
		t_rmw();
		t_refresh();
		t_battery();
		t_self();
		end_of_test();
	end
endmodule
`default_nettype wire

// file: test/dsc_dram_model.sv
// behavioural x16 dram answering the strobe controller
`timescale 1ns/1ps
`default_nettype none
module dsc_dram_model #(
	parameter real SELF_NS = 400.0
) (
	// strobes and enables
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        upper_byte_write_n,
	input  wire logic        lower_byte_write_n,
	input  wire logic        oe_n,
	// address and data
	input  wire logic [8:0]  mux_address_pins,
	input  wire logic [15:0] host_d,
	output var  logic [15:0] dev_d
);
	logic [15:0] mem [int];
	logic [8:0]  row = '0, col = '0, rcnt = '0;
	logic [15:0] last = 16'h0000;
	logic        early = 1'b0, column_first_refresh = 1'b0, lowz = 1'b0;
	int          ras_falls = 0, refs = 0, faults = 0, self_seen = 0;
	real         t_low = 0.0, ras_max = 0.0;

	function automatic logic [15:0] rd(input logic [17:0] a);
		return mem.exists(a) ? mem[a] : 16'h0000;
	endfunction

	// input path opens only on a low write enable, per lane
	task automatic wr;
		logic [15:0] v;
		v = rd({row, col});
		if (!lower_byte_write_n) v[7:0] = host_d[7:0];
		if (!upper_byte_write_n) v[15:8] = host_d[15:8];
		mem[{row, col}] = v;
	endtask

	always @(negedge ras_n) begin
		ras_falls++;
		t_low = $realtime;
		column_first_refresh = !cas_n;
		early = 1'b0;
		if (column_first_refresh) begin
			rcnt = rcnt + 9'h001; // wraps after the last row
			refs++;
		end else begin
			row = mux_address_pins;
		end
	end

	always @(posedge ras_n) if (column_first_refresh) begin
		if ($realtime - t_low >= SELF_NS) begin
			self_seen++;
			if (cas_n) faults++; // column strobe must outlast the row strobe
		end else if ($realtime - t_low > ras_max) begin
			ras_max = $realtime - t_low;
		end
	end

	always @(negedge cas_n) if (!ras_n) begin
		col = mux_address_pins;
		early = !upper_byte_write_n || !lower_byte_write_n;
		if (early) wr();
	end

	always @(negedge upper_byte_write_n or negedge lower_byte_write_n) begin
		if (!ras_n && !cas_n && !early) begin
			if (!oe_n) faults++; // outputs must float before data lands
			wr();
		end
	end

	// released lines show the inverse of the last word, never a held copy
	always @* begin
		if (oe_n || cas_n) lowz = 1'b0;
		else if (!ras_n && !early) lowz = 1'b1;
		dev_d = lowz ? rd({row, col}) : ~last; // stays driven while the row strobe cycles
		if (lowz) last = dev_d;
	end
endmodule
`default_nettype wire
